/* File: dsos_lim_if.sv */
// carries velocity settings to the limiter and its results back
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface dsos_lim_if;
   logic [31:0]        max_prof_vel;
   logic [31:0]        full_scale_vel;
   logic signed [31:0] target_vel;
   logic [31:0]        prof_limit;
   logic signed [31:0] clamped_vel;

   modport core (input max_prof_vel, input full_scale_vel, input target_vel,
                 output prof_limit, output clamped_vel);
   modport user (output max_prof_vel, output full_scale_vel, output target_vel,
                 input prof_limit, input clamped_vel);
endinterface

/* File: dsos_limiter.sv */
// profile velocity limit and target velocity clamp
// assumes inputs come from logic on mclk_i
`timescale 1ns/1ps
module dsos_limiter
   import dsos_pkg::*;
(
   input  wire logic  mclk_i,
   input  wire logic  resetn_i,
   dsos_lim_if.core   lim
);
   import dsos_pkg::*;

   logic [31:0]        prof_limit_d,  prof_limit_q;
   logic signed [31:0] clamped_vel_d, clamped_vel_q;
   logic [31:0]        smaller;

   // ==========================================================
   // limit: smaller setting, held to the 16-bit range
   always_comb begin
      smaller = (lim.max_prof_vel < lim.full_scale_vel) ? lim.max_prof_vel
                                                         : lim.full_scale_vel;
      prof_limit_d = (smaller > PROF_LIMIT_MAX) ? PROF_LIMIT_MAX : smaller;
   end

   // clamp both directions; uses last cycle's limit, one cycle of lag
   always_comb begin
      if (lim.target_vel > $signed(prof_limit_q)) begin
         clamped_vel_d = $signed(prof_limit_q);
      end else if (lim.target_vel < -$signed(prof_limit_q)) begin
         clamped_vel_d = -$signed(prof_limit_q);
      end else begin
         clamped_vel_d = lim.target_vel;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prof_limit_q  <= 32'h00000000;
         clamped_vel_q <= 32'sh00000000;
      end else begin
         prof_limit_q  <= prof_limit_d;
         clamped_vel_q <= clamped_vel_d;
      end
   end

   assign lim.prof_limit  = prof_limit_q;
   assign lim.clamped_vel = clamped_vel_q;

   // ==========================================================
   // checks
   chk_limit_is_min: assert property (
      @(posedge mclk_i) disable iff (!resetn_i)
      1 |=> (prof_limit_q <= $past(lim.max_prof_vel)) && (prof_limit_q <= $past(lim.full_scale_vel))
            && (prof_limit_q <= PROF_LIMIT_MAX))
      else $error("profile limit exceeds a setting");

   chk_clamp_bound: assert property (
      @(posedge mclk_i) disable iff (!resetn_i)
      1 |=> (clamped_vel_q <= $signed($past(prof_limit_q)))
            && (clamped_vel_q >= -$signed($past(prof_limit_q))))
      else $error("clamped velocity beyond limit");

endmodule

/* File: dsos_master_model.sv */
// network master model: sdo requests and nmt node reset pulses
// assumes the server samples these lines on rising mclk_i
`timescale 1ns/1ps
module dsos_master_model (
   input  wire logic        mclk_i,
   output logic             rx_valid_o,
   output logic [10:0]      rx_id_o,
   output logic [63:0]      rx_data_o,
   output logic             nmt_reset_o,
   input  wire logic        tx_valid_i,
   input  wire logic [63:0] tx_data_i
);
   // ==========================================
   // idle request lines
   initial begin
      rx_valid_o = 1'b0;
      rx_id_o = 11'h000;
      rx_data_o = 64'h0;
      nmt_reset_o = 1'b0;
   end

   // ==========================================
   // one frame after gap + 1 idle cycles; the reply is taken one edge later
   // released lines show the inverse, so a stale frame never looks live
   task automatic sdo(input logic [10:0] id, input logic [63:0] rq, input int gap,
                      output logic ok, output logic [63:0] rp);
      repeat (gap + 1) @(negedge mclk_i);
      rx_valid_o = 1'b1;
      rx_id_o = id;
      rx_data_o = rq;
      @(negedge mclk_i);
      rx_valid_o = 1'b0;
      rx_id_o = ~id;
      rx_data_o = ~rq;
      ok = tx_valid_i;
      rp = tx_data_i;
   endtask

   // node reset after a save; the model never enables motion at all
   task automatic nmt();
      @(negedge mclk_i);
      nmt_reset_o = 1'b1;
      @(negedge mclk_i);
      nmt_reset_o = 1'b0;
   endtask
endmodule

/* File: dsos_pkg.sv */
// constants shared by the settings object server and its limiter
// assumes an sdo frame of eight data bytes, byte 0 in bits 7:0
package dsos_pkg;

   // ==========================================================
   // object indices and sub-indices
   localparam logic [15:0] OBJ_NODE_ADDRESS   = 16'h2000;
   localparam logic [15:0] OBJ_LINK_BIT_RATE  = 16'h2001;
   localparam logic [15:0] OBJ_ABS_LIMITS     = 16'h3001;
   localparam logic [15:0] OBJ_STORE_PARAMS   = 16'h1010;
   localparam logic [7:0]  SUB_STORE_ALL      = 8'h01;
   localparam logic [7:0]  LIMITS_ENTRY_COUNT = 8'h05;
   localparam logic [7:0]  SUB_VEL_CEILING    = 8'h01;
   localparam logic [7:0]  SUB_ACC_CEILING    = 8'h02;
   localparam logic [7:0]  SUB_PROF_LIMIT     = 8'h03;

   // ==========================================================
   // frame identifiers
   localparam logic [10:0] COB_SDO_REQUEST    = 11'h600;
   localparam logic [10:0] COB_SDO_REPLY      = 11'h580;

   // ==========================================================
   // command and response bytes
   localparam logic [7:0] CMD_DOWNLOAD_1B     = 8'h2F;
   localparam logic [7:0] CMD_DOWNLOAD_2B     = 8'h2B;
   localparam logic [7:0] CMD_DOWNLOAD_4B     = 8'h23;
   localparam logic [7:0] CMD_UPLOAD          = 8'h40;
   localparam logic [7:0] RSP_DOWNLOAD_OK     = 8'h60;
   localparam logic [7:0] RSP_UPLOAD_1B       = 8'h4F;
   localparam logic [7:0] RSP_UPLOAD_2B       = 8'h4B;
   localparam logic [7:0] RSP_UPLOAD_4B       = 8'h43;
   localparam logic [7:0] RSP_ABORT           = 8'h80;
   localparam logic [31:0] SAVE_SIGNATURE     = 32'h65766173;

   // ==========================================================
   // abort codes
   localparam logic [31:0] ABORT_OUT_OF_RANGE = 32'h06040030;
   localparam logic [31:0] ABORT_NO_SUBINDEX  = 32'h06090011;
   localparam logic [31:0] ABORT_READ_ONLY    = 32'h06010002;
   localparam logic [31:0] ABORT_NO_OBJECT    = 32'h06020000;
   localparam logic [31:0] ABORT_BAD_COMMAND  = 32'h05040001;
   localparam logic [31:0] ABORT_BAD_LENGTH   = 32'h06070010;
   localparam logic [31:0] ABORT_NOT_STORED   = 32'h08000020;

   // ==========================================================
   // reset values and ranges
   localparam logic [7:0]  NODE_ADDRESS_RESET = 8'h01;
   localparam logic [7:0]  NODE_ADDRESS_MIN   = 8'h01;
   localparam logic [7:0]  NODE_ADDRESS_MAX   = 8'h7F;
   localparam logic [15:0] BIT_RATE_RESET     = 16'h03E8;
   localparam logic [31:0] PROF_LIMIT_MAX     = 32'h0000FFFF;
   localparam logic [31:0] CEILING_MAX        = 32'h7FFFFFFF;

   typedef enum logic [0:0] {
      ST_IDLE,
      ST_SAVE_ARMED
   } dsos_store_t;

endpackage

/* File: dsos_server.sv */
// settings object server: node address, bit rate, store, absolute limits
// assumes frames arrive from a can controller on mclk_i, one per pulse,
// and that a persistent store outside keeps the committed values
//
// Overview of operation
// - node address 1..127, used after power cycle
// - out-of-range write aborts 0x06040030, no change
// - bit-rate code is kbit/s, nine valid codes
// - write, SAVE to 1010, node reset commits
// - node address via 0x2F, answer 0x60 zeros
// - bit rate via 0x2B, code in low bytes
// - absolute limits are read only; ceilings fixed, profile limit follows settings
// - limits array reports five entries
// - ceilings 0..2147483647, profile limit 0..65535
// - profile limit is smaller of two settings
// - target velocity clamped to profile limit
// - absent limits sub-index aborts 0x06090011
// - write to read-only entry aborts 0x06010002
`timescale 1ns/1ps
module dsos_server
   import dsos_pkg::*;
#(
   parameter logic [31:0] VEL_CEILING = 32'h00001194,
   parameter logic [31:0] ACC_CEILING = 32'h000008B4
)(
   input  wire logic                mclk_i,
   input  wire logic                resetn_i,
   input  wire logic                rx_valid_i,
   input  wire logic [10:0]         rx_id_i,
   input  wire logic [63:0]         rx_data_i,
   output logic                     tx_valid_o,
   output logic [10:0]              tx_id_o,
   output logic [63:0]              tx_data_o,
   input  wire logic                nmt_reset_i,
   input  wire logic [7:0]          nv_node_address_i,
   input  wire logic [15:0]         nv_bit_rate_i,
   output logic                     nv_commit_o,
   output logic [7:0]               nv_node_address_o,
   output logic [15:0]              nv_bit_rate_o,
   output logic [7:0]               active_node_address_o,
   output logic [15:0]              active_bit_rate_o,
   input  wire logic [31:0]         max_prof_vel_i,
   input  wire logic [31:0]         full_scale_vel_i,
   input  wire logic signed [31:0]  target_vel_i,
   output logic [31:0]              prof_limit_o,
   output logic signed [31:0]       clamped_vel_o
);
   import dsos_pkg::*;

   dsos_lim_if lim ();

   // ==========================================================
   // state
   logic              loaded_d,      loaded_q;
   logic [7:0]        act_node_d,    act_node_q;
   logic [15:0]       act_rate_d,    act_rate_q;
   logic [7:0]        pend_node_d,   pend_node_q;
   logic [15:0]       pend_rate_d,   pend_rate_q;
   dsos_store_t       store_d,       store_q;
   logic              commit_d,      commit_q;
   logic              tx_valid_d,    tx_valid_q;
   logic [10:0]       tx_id_d,       tx_id_q;
   logic [63:0]       tx_data_d,     tx_data_q;

   // decoded request
   logic [7:0]        rq_cmd;
   logic [15:0]       rq_index;
   logic [7:0]        rq_sub;
   logic [31:0]       rq_data;
   logic              rq_hit;
   logic              abort;
   logic [31:0]       abort_code;
   logic [7:0]        rsp_cmd;
   logic [31:0]       rsp_data;
   logic              wr_node, wr_rate, wr_save;

   // nine link bit-rate codes
   function automatic logic rate_code_ok(input logic [15:0] c);
      case (c)
         16'h000A, 16'h0014, 16'h0032, 16'h0064, 16'h007D,
         16'h00FA, 16'h01F4, 16'h0320, 16'h03E8: rate_code_ok = 1'b1;
         default: rate_code_ok = 1'b0;
      endcase
   endfunction

   function automatic logic node_ok(input logic [7:0] n);
      node_ok = (n >= NODE_ADDRESS_MIN) && (n <= NODE_ADDRESS_MAX);
   endfunction

   // ==========================================================
   // frame layout: cmd, index lsb first, sub-index, data
   always_comb begin
      rq_cmd   = rx_data_i[7:0];
      rq_index = {rx_data_i[23:16], rx_data_i[15:8]};
      rq_sub   = rx_data_i[31:24];
      rq_data  = rx_data_i[63:32];
      rq_hit   = rx_valid_i && (rx_id_i == (COB_SDO_REQUEST | {4'h0, act_node_q[6:0]}));
   end

   // ==========================================================
   // object dictionary decode and answer
   always_comb begin
      abort      = 1'b0;
      abort_code = 32'h00000000;
      rsp_cmd    = RSP_DOWNLOAD_OK;
      rsp_data   = 32'h00000000;
      wr_node    = 1'b0;
      wr_rate    = 1'b0;
      wr_save    = 1'b0;
      case (rq_index)
         OBJ_NODE_ADDRESS: begin
            if (rq_sub != 8'h00) begin
               abort = 1'b1;
               abort_code = ABORT_NO_SUBINDEX;
            end else if (rq_cmd == CMD_UPLOAD) begin
               rsp_cmd  = RSP_UPLOAD_1B;
               rsp_data = {24'h000000, pend_node_q};
            end else if (rq_cmd != CMD_DOWNLOAD_1B) begin
               abort = 1'b1;
               abort_code = ABORT_BAD_LENGTH;
            end else if (!node_ok(rq_data[7:0])) begin
               abort = 1'b1;
               abort_code = ABORT_OUT_OF_RANGE;
            end else begin
               wr_node = 1'b1;
            end
         end
         OBJ_LINK_BIT_RATE: begin
            if (rq_sub != 8'h00) begin
               abort = 1'b1;
               abort_code = ABORT_NO_SUBINDEX;
            end else if (rq_cmd == CMD_UPLOAD) begin
               rsp_cmd  = RSP_UPLOAD_2B;
               rsp_data = {16'h0000, pend_rate_q};
            end else if (rq_cmd != CMD_DOWNLOAD_2B) begin
               abort = 1'b1;
               abort_code = ABORT_BAD_LENGTH;
            end else if (!rate_code_ok(rq_data[15:0])) begin
               abort = 1'b1;
               abort_code = ABORT_OUT_OF_RANGE;
            end else begin
               wr_rate = 1'b1;
            end
         end
         OBJ_ABS_LIMITS: begin
            if (rq_sub > LIMITS_ENTRY_COUNT) begin
               abort = 1'b1;
               abort_code = ABORT_NO_SUBINDEX;
            end else if (rq_cmd != CMD_UPLOAD) begin
               abort = 1'b1;
               abort_code = ABORT_READ_ONLY;
            end else begin
               rsp_cmd = RSP_UPLOAD_4B;
               case (rq_sub)
                  8'h00: begin
                     rsp_cmd  = RSP_UPLOAD_1B;
                     rsp_data = {24'h000000, LIMITS_ENTRY_COUNT};
                  end
                  SUB_VEL_CEILING: rsp_data = VEL_CEILING & CEILING_MAX;
                  SUB_ACC_CEILING: rsp_data = ACC_CEILING & CEILING_MAX;
                  SUB_PROF_LIMIT:  rsp_data = lim.prof_limit;
                  default:         rsp_data = 32'h00000000; // unused entries
               endcase
            end
         end
         OBJ_STORE_PARAMS: begin
            if (rq_sub != SUB_STORE_ALL) begin
               abort = 1'b1;
               abort_code = ABORT_NO_SUBINDEX;
            end else if (rq_cmd != CMD_DOWNLOAD_4B) begin
               abort = 1'b1;
               abort_code = ABORT_BAD_COMMAND;
            end else if (rq_data != SAVE_SIGNATURE) begin
               abort = 1'b1;
               abort_code = ABORT_NOT_STORED;
            end else begin
               wr_save = 1'b1;
            end
         end
         default: begin
            abort = 1'b1;
            abort_code = ABORT_NO_OBJECT;
         end
      endcase
   end

   // ==========================================================
   // settings: active taken once after reset, pending from writes
   always_comb begin
      loaded_d    = 1'b1;
      act_node_d  = act_node_q;
      act_rate_d  = act_rate_q;
      pend_node_d = pend_node_q;
      pend_rate_d = pend_rate_q;
      if (!loaded_q) begin
         // a corrupt stored value falls back to the default
         if (node_ok(nv_node_address_i)) begin
            act_node_d  = nv_node_address_i;
            pend_node_d = nv_node_address_i;
         end
         if (rate_code_ok(nv_bit_rate_i)) begin
            act_rate_d  = nv_bit_rate_i;
            pend_rate_d = nv_bit_rate_i;
         end
      end else begin
         if (rq_hit && wr_node) begin
            pend_node_d = rq_data[7:0];
         end
         if (rq_hit && wr_rate) begin
            pend_rate_d = rq_data[15:0];
         end
      end
   end

   // ==========================================================
   // store sequence: SAVE arms, node reset commits pending
   always_comb begin
      store_d  = store_q;
      commit_d = 1'b0;
      case (store_q)
         ST_IDLE: begin
            if (rq_hit && loaded_q && wr_save) begin
               store_d = ST_SAVE_ARMED;
            end
         end
         ST_SAVE_ARMED: begin
            if (nmt_reset_i) begin
               // a save in the same cycle re-arms: the newer request wins
               commit_d = 1'b1;
               store_d  = (rq_hit && loaded_q && wr_save) ? ST_SAVE_ARMED : ST_IDLE;
            end
         end
         default: store_d = ST_IDLE;
      endcase
   end

   // ==========================================================
   // reply frame, one cycle after the request
   always_comb begin
      tx_valid_d = rq_hit && loaded_q;
      tx_id_d    = tx_id_q;
      tx_data_d  = tx_data_q;
      if (rq_hit && loaded_q) begin
         tx_id_d = COB_SDO_REPLY | {4'h0, act_node_q[6:0]};
         if (abort) begin
            tx_data_d = {abort_code, rq_sub, rq_index[15:8], rq_index[7:0], RSP_ABORT};
         end else begin
            tx_data_d = {rsp_data, rq_sub, rq_index[15:8], rq_index[7:0], rsp_cmd};
         end
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         loaded_q    <= 1'b0;
         act_node_q  <= NODE_ADDRESS_RESET;
         act_rate_q  <= BIT_RATE_RESET;
         pend_node_q <= NODE_ADDRESS_RESET;
         pend_rate_q <= BIT_RATE_RESET;
         store_q     <= ST_IDLE;
         commit_q    <= 1'b0;
         tx_valid_q  <= 1'b0;
         tx_id_q     <= 11'h000;
         tx_data_q   <= 64'h0000000000000000;
      end else begin
         loaded_q    <= loaded_d;
         act_node_q  <= act_node_d;
         act_rate_q  <= act_rate_d;
         pend_node_q <= pend_node_d;
         pend_rate_q <= pend_rate_d;
         store_q     <= store_d;
         commit_q    <= commit_d;
         tx_valid_q  <= tx_valid_d;
         tx_id_q     <= tx_id_d;
         tx_data_q   <= tx_data_d;
      end
   end

   // ==========================================================
   // limiter
   assign lim.max_prof_vel   = max_prof_vel_i;
   assign lim.full_scale_vel = full_scale_vel_i;
   assign lim.target_vel     = target_vel_i;

   dsos_limiter u_limiter (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .lim      (lim.core)
   );

   // ==========================================================
   // outputs
   assign tx_valid_o            = tx_valid_q;
   assign tx_id_o               = tx_id_q;
   assign tx_data_o             = tx_data_q;
   assign nv_commit_o           = commit_q;
   assign nv_node_address_o     = pend_node_q;
   assign nv_bit_rate_o         = pend_rate_q;
   assign active_node_address_o = act_node_q;
   assign active_bit_rate_o     = act_rate_q;
   assign prof_limit_o          = lim.prof_limit;
   assign clamped_vel_o         = lim.clamped_vel;

   // ==========================================================
   // checks
   chk_active_held: assert property (
      @(posedge mclk_i) disable iff (!resetn_i)
      loaded_q |=> $stable(act_node_q) && $stable(act_rate_q))
      else $error("active link setting changed without power cycle");

   chk_range_abort: assert property (
      @(posedge mclk_i) disable iff (!resetn_i)
      (rq_hit && loaded_q && rq_index == OBJ_NODE_ADDRESS && rq_sub == 8'h00
       && rq_cmd == CMD_DOWNLOAD_1B && !node_ok(rq_data[7:0]))
      |=> tx_valid_q && tx_data_q[63:32] == ABORT_OUT_OF_RANGE && $stable(pend_node_q))
      else $error("out-of-range node address not refused");

   chk_rate_valid: assert property (
      @(posedge mclk_i) disable iff (!resetn_i)
      1 |-> rate_code_ok(pend_rate_q) && rate_code_ok(act_rate_q))
      else $error("bit-rate setting holds an invalid code");

   chk_commit_seq: assert property (
      @(posedge mclk_i) disable iff (!resetn_i)
      commit_q |-> $past(store_q) == ST_SAVE_ARMED && $past(nmt_reset_i))
      else $error("commit without save and node reset");

   chk_node_ack: assert property (
      @(posedge mclk_i) disable iff (!resetn_i)
      (rq_hit && loaded_q && rq_index == OBJ_NODE_ADDRESS && rq_sub == 8'h00
       && rq_cmd == CMD_DOWNLOAD_1B && node_ok(rq_data[7:0]))
      |=> tx_data_q[7:0] == RSP_DOWNLOAD_OK && tx_data_q[63:32] == 32'h00000000
          && pend_node_q == $past(rq_data[7:0]))
      else $error("node address write not acknowledged");

   chk_reply_id: assert property (
      @(posedge mclk_i) disable iff (!resetn_i)
      tx_valid_q |-> tx_id_q == (COB_SDO_REPLY | {4'h0, act_node_q[6:0]}))
      else $error("reply identifier wrong");

   chk_subidx_abort: assert property (
      @(posedge mclk_i) disable iff (!resetn_i)
      (rq_hit && loaded_q && rq_index == OBJ_ABS_LIMITS && rq_sub > LIMITS_ENTRY_COUNT)
      |=> tx_data_q[7:0] == RSP_ABORT && tx_data_q[63:32] == ABORT_NO_SUBINDEX)
      else $error("absent sub-index not refused");

   chk_read_only: assert property (
      @(posedge mclk_i) disable iff (!resetn_i)
      (rq_hit && loaded_q && rq_index == OBJ_ABS_LIMITS && rq_sub <= LIMITS_ENTRY_COUNT
       && rq_cmd != CMD_UPLOAD)
      |=> tx_data_q[7:0] == RSP_ABORT && tx_data_q[63:32] == ABORT_READ_ONLY)
      else $error("write to read-only limit not refused");

endmodule

/* File: test_drive_settings_object_server.sv */
// self-checking bench for the settings object server and its limiter
// assumes dsos_pkg and dsos_master_model are compiled before it
`timescale 1ns/1ps
module test_drive_settings_object_server;
   import dsos_pkg::*;
   localparam logic [31:0] VEL = 32'h000186A0;
   localparam logic [31:0] ACC = 32'h000008B4;
   logic        mclk = 1'b0, resetn = 1'b0, rx_valid, nmt, tx_valid, commit, ok;
   logic [10:0] rx_id, tx_id;
   logic [63:0] rx_data, tx_data, rp;
   logic [7:0]  nv_node_in = 8'h01, nv_node, act_node;
   logic [15:0] nv_rate_in = 16'h03E8, nv_rate, act_rate;
   logic [31:0] max_pv = 32'h0, full_sv = 32'h0, plim;
   logic signed [31:0] tgt = 32'sh0, clamp;
   int          errors = 0, n_tests = 0, seed = 18250, m_node, m_rate, a_node, a_rate, pl, cv;
   logic [31:0] nodes [6];
   logic [15:0] rates [11] = '{16'h000A, 16'h0014, 16'h0032, 16'h0064, 16'h007D, 16'h00FA,
                               16'h01F4, 16'h0320, 16'h03E8, 16'h0000, 16'h03E7};

   // ==========================================
   // clock, design and master
   always #2.5 mclk = ~mclk;
   dsos_server #(.VEL_CEILING(VEL), .ACC_CEILING(ACC)) dsos_server_i (
      .mclk_i(mclk), .resetn_i(resetn), .rx_valid_i(rx_valid), .rx_id_i(rx_id),
      .rx_data_i(rx_data), .tx_valid_o(tx_valid), .tx_id_o(tx_id), .tx_data_o(tx_data),
      .nmt_reset_i(nmt), .nv_node_address_i(nv_node_in), .nv_bit_rate_i(nv_rate_in),
      .nv_commit_o(commit), .nv_node_address_o(nv_node), .nv_bit_rate_o(nv_rate),
      .active_node_address_o(act_node), .active_bit_rate_o(act_rate),
      .max_prof_vel_i(max_pv), .full_scale_vel_i(full_sv), .target_vel_i(tgt),
      .prof_limit_o(plim), .clamped_vel_o(clamp));
   dsos_master_model dsos_master_model_i (
      .mclk_i(mclk), .rx_valid_o(rx_valid), .rx_id_o(rx_id), .rx_data_o(rx_data),
      .nmt_reset_o(nmt), .tx_valid_i(tx_valid), .tx_data_i(tx_data));

   // ==========================================
   // comparison, verdict and reference model
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   function automatic bit rate_ok(input logic [15:0] r);
      for (int i = 0; i < 9; i++) if (rates[i] === r) return 1'b1;
      return 1'b0;
   endfunction

   // reply the server owes for one request; updates pending values
   function automatic logic [63:0] expect_reply(input logic [63:0] rq);
      logic [7:0] cmd, sub, rsp;
      logic [31:0] d, v, ab;
      cmd = rq[7:0];
      sub = rq[31:24];
      d = rq[63:32];
      ab = 32'h0;
      v = 32'h0;
      rsp = RSP_DOWNLOAD_OK;
      if (rq[23:8] == OBJ_NODE_ADDRESS || rq[23:8] == OBJ_LINK_BIT_RATE) begin
         if (sub != 8'h00) ab = ABORT_NO_SUBINDEX;
         else if (cmd == CMD_UPLOAD) begin
            rsp = rq[8] ? RSP_UPLOAD_2B : RSP_UPLOAD_1B;
            v = rq[8] ? m_rate : m_node;
         end else if (cmd != (rq[8] ? CMD_DOWNLOAD_2B : CMD_DOWNLOAD_1B)) ab = ABORT_BAD_LENGTH;
         else if (!rq[8]) begin
            if (d[7:0] >= 8'h01 && d[7:0] <= 8'h7F) m_node = d[7:0];
            else ab = ABORT_OUT_OF_RANGE;
         end else if (rate_ok(d[15:0])) m_rate = d[15:0];
         else ab = ABORT_OUT_OF_RANGE;
      end else if (rq[23:8] == OBJ_ABS_LIMITS) begin
         if (sub > 8'h05) ab = ABORT_NO_SUBINDEX;
         else if (cmd != CMD_UPLOAD) ab = ABORT_READ_ONLY;
         else begin
            rsp = (sub == 8'h00) ? RSP_UPLOAD_1B : RSP_UPLOAD_4B;
            v = (sub == 8'h00) ? 32'h5 : (sub == 8'h01) ? VEL : (sub == 8'h02) ? ACC :
                (sub == 8'h03) ? pl : 32'h0;
         end
      end else if (rq[23:8] == OBJ_STORE_PARAMS) begin
         if (sub != 8'h01) ab = ABORT_NO_SUBINDEX;
         else if (cmd != CMD_DOWNLOAD_4B) ab = ABORT_BAD_COMMAND;
         else if (d != SAVE_SIGNATURE) ab = ABORT_NOT_STORED;
      end else ab = ABORT_NO_OBJECT;
      return (ab != 32'h0) ? {ab, rq[31:8], RSP_ABORT} : {v, rq[31:8], rsp};
   endfunction

   // one request to this node, reply and identifier compared
   task automatic xfer(input logic [15:0] idx, input logic [7:0] sub, input logic [7:0] cmd,
                       input logic [31:0] d, input int gap);
      logic [63:0] rq;
      rq = {d, sub, idx, cmd};
      dsos_master_model_i.sdo(11'h600 | 11'(a_node), rq, gap, ok, rp);
      check(64'(ok), 64'h1);
      check(rp, expect_reply(rq));
      check(64'(tx_id), 64'(11'h580 | 11'(a_node)));
   endtask

   // power cycle with given stored values; invalid ones fall back to defaults
   task automatic power_cycle(input logic [7:0] n, input logic [15:0] r);
      @(negedge mclk);
      resetn = 1'b0;
      nv_node_in = n;
      nv_rate_in = r;
      repeat (5) @(negedge mclk);
      resetn = 1'b1;
      repeat (2) @(negedge mclk);
      a_node = (n >= 8'h01 && n <= 8'h7F) ? n : 1;
      a_rate = rate_ok(r) ? r : 16'h03E8;
      m_node = a_node;
      m_rate = a_rate;
      check(64'({act_node, act_rate}), 64'({8'(a_node), 16'(a_rate)}));
   endtask

   // ==========================================
   // main sequence
   initial begin
      nodes = '{32'h00, 32'h80, 32'hFF, 32'h01, 32'h7F, {$random(seed)} % 128};
      power_cycle(8'h01, 16'h03E8);
      repeat (24) begin
         max_pv = {$random(seed)} % (VEL + 1);
         full_sv = {$random(seed)} % (VEL + 1);
         tgt = $random(seed) % 200000;
         repeat (2) @(negedge mclk);
         pl = (max_pv < full_sv) ? max_pv : full_sv;
         pl = (pl > 65535) ? 65535 : pl;
         cv = (tgt > pl) ? pl : ((tgt < -pl) ? -pl : tgt);
         check(64'(plim), 64'(pl));
         check(64'(clamp), 64'(cv));
      end
      foreach (nodes[i]) xfer(OBJ_NODE_ADDRESS, 8'h00, CMD_DOWNLOAD_1B, nodes[i], i % 2);
      foreach (rates[i]) xfer(OBJ_LINK_BIT_RATE, 8'h00, CMD_DOWNLOAD_2B, 32'(rates[i]), 0);
      xfer(OBJ_NODE_ADDRESS, 8'h01, CMD_DOWNLOAD_1B, 32'h05, 0);
      xfer(OBJ_LINK_BIT_RATE, 8'h00, CMD_DOWNLOAD_1B, 32'h0A, 0);
      xfer(OBJ_NODE_ADDRESS, 8'h00, CMD_UPLOAD, 32'h0, 1);
      xfer(OBJ_LINK_BIT_RATE, 8'h00, CMD_UPLOAD, 32'h0, 0);
      check(64'({act_node, act_rate}), 64'({8'(a_node), 16'(a_rate)}));
      for (int s = 0; s < 7; s++) xfer(OBJ_ABS_LIMITS, 8'(s), CMD_UPLOAD, 32'h0, s % 2);
      xfer(OBJ_ABS_LIMITS, 8'h01, CMD_DOWNLOAD_4B, 32'h0, 0);
      xfer(OBJ_ABS_LIMITS, 8'h06, CMD_DOWNLOAD_4B, 32'h0, 0);
      xfer(OBJ_ABS_LIMITS, 8'h01, CMD_UPLOAD, 32'h0, 0);
      xfer(16'h2002, 8'h00, CMD_UPLOAD, 32'h0, 0);
      // frame for another node must stay unanswered
      dsos_master_model_i.sdo(11'h600 | 11'(a_node + 1), 64'h2F, 0, ok, rp);
      check(64'(ok), 64'h0);
      // store refusals, then write, save and node reset
      xfer(OBJ_STORE_PARAMS, 8'h02, CMD_DOWNLOAD_4B, SAVE_SIGNATURE, 0);
      xfer(OBJ_STORE_PARAMS, 8'h01, CMD_DOWNLOAD_1B, SAVE_SIGNATURE, 0);
      xfer(OBJ_STORE_PARAMS, 8'h01, CMD_DOWNLOAD_4B, 32'h0, 0);
      xfer(OBJ_NODE_ADDRESS, 8'h00, CMD_DOWNLOAD_1B, 32'h03, 0);
      xfer(OBJ_LINK_BIT_RATE, 8'h00, CMD_DOWNLOAD_2B, 32'h01F4, 0);
      xfer(OBJ_STORE_PARAMS, SUB_STORE_ALL, CMD_DOWNLOAD_4B, SAVE_SIGNATURE, 3);
      dsos_master_model_i.nmt();
      check(64'(commit), 64'h1);
      check(64'({nv_node, nv_rate}), 64'({m_node[7:0], m_rate[15:0]}));
      check(64'(act_node), 64'(a_node));
      @(negedge mclk);
      check(64'(commit), 64'h0);
      power_cycle(nv_node, nv_rate);
      xfer(OBJ_NODE_ADDRESS, 8'h00, CMD_UPLOAD, 32'h0, 0);
      dsos_master_model_i.nmt();
      check(64'(commit), 64'h0);
      power_cycle(8'h80, 16'h0001);
      tally_and_finish();
   end

   // a hang is cut short and counted
   initial begin
      #200000;
      errors++;
      tally_and_finish();
   end
endmodule
